// ### mmmc_top.v
// Memory map, bus arbitration and operating mode control unit
`timescale 1ns/1ps
`include "mmmc_regs.vh"

// Notes on behaviour
// - Mode pin captured at reset pin rise
// - Pin drives mode in reset, bit after
// - Captured pin level readable in mode bit
// - Forbidden mode write ignored, locks outside special
// - Secured device ignores all mode writes
// - Special mode enters background debug after reset
// - Core unmapped access raises system reset
// - Arbitrate core and debug module accesses
// - Paging reaches 256 kByte global space
// - Separate translation for core and debug
// - Secured device denies external flash access
// - Mode bit at top, rest zero
// - Direct page supplies address bits 15..8
// - Direct page write-once in normal mode
// - Page index selects 16 kB flash window
// - Page index resets to 0x0E
module mmmc_top (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        reset_pin_n_i,
    input  wire        mode_select_pin_i,
    input  wire        secure_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        cpu_req_i,
    input  wire        cpu_we_i,
    input  wire        cpu_direct_i,
    input  wire [15:0] cpu_addr_i,
    input  wire        bdm_req_i,
    input  wire        bdm_we_i,
    input  wire [15:0] bdm_addr_i,
    output reg         mem_req_o,
    output reg         mem_we_o,
    output reg  [17:0] mem_addr_o,
    output reg         grant_cpu_o,
    output reg         grant_bdm_o,
    output reg         sys_reset_o,
    output reg         flash_deny_o,
    output reg         normal_single_chip_o,
    output reg         background_debug_mode_o,
    output reg         irq_o
);

    // Local to global translation; one scheme per master
    function [17:0] mmmc_xlate;
        input [15:0] a;
        input [3:0]  pg;
        reg   [3:0]  sel_pg;
        begin
            case (a[15:14])
                `MMMC_WIN_LOW:   sel_pg = `MMMC_PAGE_LOW;
                `MMMC_WIN_MID:   sel_pg = `MMMC_PAGE_MID;
                `MMMC_WIN_PAGED: sel_pg = pg;
                default:         sel_pg = `MMMC_PAGE_TOP;
            endcase
            mmmc_xlate = {sel_pg, a[13:0]};
        end
    endfunction

    // Addresses that belong to no on-chip resource
    function mmmc_unimpl;
        input [15:0] a;
        input [3:0]  pg;
        begin
            mmmc_unimpl =
                ((a[15:14] == `MMMC_WIN_LOW) && (a >= `MMMC_REG_TOP) &&
                 (a < `MMMC_RAM_LO)) ||
                ((a[15:14] == `MMMC_WIN_PAGED) && (pg < `MMMC_FLASH_PG_MIN));
        end
    endfunction

    // Register index match, shared by the write strobes
    function mmmc_hit;
        input [5:0] i;
        input [5:0] want;
        begin
            mmmc_hit = (i == want);
        end
    endfunction

    // Pin synchronisers: bit 0 reset pin, bit 1 mode select pin
    wire [1:0] pin_raw;
    reg  [1:0] pin_s1_q;
    reg  [1:0] pin_s2_q;
    reg  [1:0] pin_s3_q;
    reg  [1:0] pin_lvl_q;

    assign pin_raw = {mode_select_pin_i, reset_pin_n_i};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
            // No reset: the pins must be tracked while rst_i is high
            always @(posedge clk_i) begin
                pin_s1_q[gi] <= pin_raw[gi];
                pin_s2_q[gi] <= pin_s1_q[gi];
                pin_s3_q[gi] <= pin_s2_q[gi];
                // A change counts once two stages agree; filters glitches
                if (pin_s2_q[gi] == pin_s3_q[gi]) begin
                    pin_lvl_q[gi] <= pin_s3_q[gi];
                end
            end
        end
    endgenerate

    wire rpin_lvl = pin_lvl_q[0];
    wire mpin_lvl = pin_lvl_q[1];

    // Register state
    reg        mode_q;
    reg        lock_q;
    reg  [7:0] direct_q;
    reg        direct_wr_q;
    reg  [3:0] flash_window_page_q;
    reg  [3:0] bdm_page_q;
    reg  [`MMMC_EV_W-1:0] stat_q;
    reg  [`MMMC_EV_W-1:0] mask_q;
    reg        bdm_act_q;
    reg        boot_q;
    reg  [`MMMC_EV_W-1:0] ev_d;

    // Bus decode
    // Writes need byte lane 0, where all register bits sit
    wire       acc  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wr   = acc & wb_we_i & wb_sel_i[0];
    wire [5:0] idx  = wb_adr_i[7:2];
    wire [7:0] wdat = wb_dat_i[7:0];

    wire wr_mode   = wr & mmmc_hit(idx, `MMMC_IDX_MODE);
    wire wr_direct = wr & mmmc_hit(idx, `MMMC_IDX_DIRECT);
    wire wr_flash_window_page  = wr & mmmc_hit(idx, `MMMC_IDX_FLASH_WINDOW_PAGE);
    wire wr_bpage  = wr & mmmc_hit(idx, `MMMC_IDX_BDMPAGE);
    wire wr_stat   = wr & mmmc_hit(idx, `MMMC_IDX_STAT);
    wire wr_mask   = wr & mmmc_hit(idx, `MMMC_IDX_MASK);
    wire wr_ctrl   = wr & mmmc_hit(idx, `MMMC_IDX_CTRL);

    // Same value, or the step up to normal mode
    wire mode_ok  = (wdat[`MMMC_MODE_BIT] == mode_q) ||
                    (wdat[`MMMC_MODE_BIT] == `MMMC_MODE_NS);
    wire mode_try = wr_mode & ~secure_i & ~lock_q;
    wire mode_bad = mode_try & ~mode_ok;

    // Master address paths
    wire [15:0] cpu_local = cpu_direct_i ?
                            {direct_q, cpu_addr_i[7:0]} : cpu_addr_i;
    wire [17:0] cpu_glob  = mmmc_xlate(cpu_local, flash_window_page_q);
    wire [17:0] bdm_glob  = mmmc_xlate(bdm_addr_i, bdm_page_q);
    wire        cpu_bad   = mmmc_unimpl(cpu_local, flash_window_page_q);
    wire        bdm_flash = (bdm_glob >= `MMMC_FLASH_BASE);

    // Debug module has priority so a halted core cannot starve it
    wire gnt_bdm   = bdm_req_i;
    wire gnt_cpu   = cpu_req_i & ~bdm_req_i;
    wire deny_bdm  = gnt_bdm & secure_i & bdm_flash;
    wire unimp_cpu = gnt_cpu & cpu_bad;

    always @* begin
        ev_d                  = {`MMMC_EV_W{1'b0}};
        ev_d[`MMMC_EV_UNIMPL] = unimp_cpu;
        ev_d[`MMMC_EV_MODE]   = mode_bad;
        ev_d[`MMMC_EV_DENY]   = deny_bdm;
    end

    // Operating mode
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= mpin_lvl;
        end else if (!rpin_lvl) begin
            mode_q <= mpin_lvl;
        end else if (mode_try && mode_ok) begin
            mode_q <= wdat[`MMMC_MODE_BIT];
        end
    end

    // Lock after a forbidden write; special mode stays writable
    always @(posedge clk_i) begin
        if (rst_i || !rpin_lvl) begin
            lock_q <= 1'b0;
        end else if (mode_bad && mode_q != `MMMC_MODE_SS) begin
            lock_q <= 1'b1;
        end
    end

    // Reset pin release: last pin level while low is the captured mode
    reg rpin_prev_q;
    always @(posedge clk_i) begin
        if (rst_i) begin
            // Idle level of the pin, so rst_i alone makes no false edge
            rpin_prev_q <= 1'b1;
        end else begin
            rpin_prev_q <= rpin_lvl;
        end
    end

    // Pin reset release; mode_q still holds the captured pin level
    wire pin_rise = rpin_lvl & ~rpin_prev_q;

    // Paging and direct page registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            direct_q    <= `MMMC_DIRECT_RST;
            direct_wr_q <= 1'b0;
        end else if (wr_direct &&
                     (mode_q == `MMMC_MODE_SS || !direct_wr_q)) begin
            direct_q    <= wdat;
            direct_wr_q <= 1'b1;
        end
    end

    // Both masters start on the linear flash page
    always @(posedge clk_i) begin
        if (rst_i) begin
            flash_window_page_q <= `MMMC_FLASH_WINDOW_PAGE_RST;
        end else if (wr_flash_window_page) begin
            flash_window_page_q <= wdat[3:0];
        end
    end

    // Debug page of its own, so the core's page is left alone
    always @(posedge clk_i) begin
        if (rst_i) begin
            bdm_page_q <= `MMMC_FLASH_WINDOW_PAGE_RST;
        end else if (wr_bpage) begin
            bdm_page_q <= wdat[3:0];
        end
    end

    // Event mask, same layout as status
    always @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= `MMMC_MASK_RST;
        end else if (wr_mask) begin
            mask_q <= wdat[`MMMC_EV_W-1:0];
        end
    end

    // Sticky events; a new event wins over a write-one clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= {`MMMC_EV_W{1'b0}};
        end else if (wr_stat) begin
            stat_q <= (stat_q & ~wdat[`MMMC_EV_W-1:0]) | ev_d;
        end else begin
            stat_q <= stat_q | ev_d;
        end
    end

    // Background debug entry after each reset in special mode
    always @(posedge clk_i) begin
        if (rst_i) begin
            boot_q    <= 1'b1;
            bdm_act_q <= 1'b0;
        end else begin
            boot_q <= 1'b0;
            if (boot_q || pin_rise) begin
                bdm_act_q <= (mode_q == `MMMC_MODE_SS);
            end else if (wr_ctrl && wdat[`MMMC_CTRL_BDM]) begin
                bdm_act_q <= 1'b0;
            end
        end
    end

    // Memory side outputs, one cycle after the request
    always @(posedge clk_i) begin
        if (rst_i) begin
            grant_cpu_o  <= 1'b0;
            grant_bdm_o  <= 1'b0;
            sys_reset_o  <= 1'b0;
            flash_deny_o <= 1'b0;
        end else begin
            grant_cpu_o  <= gnt_cpu;
            grant_bdm_o  <= gnt_bdm;
            sys_reset_o  <= unimp_cpu;
            flash_deny_o <= deny_bdm;
        end
    end

    // Refused accesses never reach memory
    always @(posedge clk_i) begin
        if (rst_i) begin
            mem_req_o <= 1'b0;
            mem_we_o  <= 1'b0;
        end else begin
            mem_req_o <= (gnt_bdm & ~deny_bdm) | (gnt_cpu & ~cpu_bad);
            mem_we_o  <= gnt_bdm ? bdm_we_i : cpu_we_i;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            mem_addr_o <= 18'h00000;
        end else begin
            mem_addr_o <= gnt_bdm ? bdm_glob : cpu_glob;
        end
    end

    // Status pins
    always @(posedge clk_i) begin
        if (rst_i) begin
            normal_single_chip_o    <= 1'b0;
            background_debug_mode_o <= 1'b0;
        end else begin
            normal_single_chip_o    <= (mode_q == `MMMC_MODE_NS);
            background_debug_mode_o <= bdm_act_q;
        end
    end

    // Irq follows status one cycle late; a level, not a pulse
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(stat_q & mask_q);
        end
    end

    // Wishbone read data and ack; unmapped indices read zero
    reg [7:0] rdat;
    always @* begin
        rdat = 8'h00;
        case (idx)
            `MMMC_IDX_MODE:    rdat = {mode_q, 7'h00};
            `MMMC_IDX_DIRECT:  rdat = direct_q;
            `MMMC_IDX_FLASH_WINDOW_PAGE:   rdat = {4'h0, flash_window_page_q};
            `MMMC_IDX_BDMPAGE: rdat = {4'h0, bdm_page_q};
            `MMMC_IDX_STAT:    rdat = {5'h00, stat_q};
            `MMMC_IDX_MASK:    rdat = {5'h00, mask_q};
            `MMMC_IDX_CTRL:    rdat = {5'h00, secure_i, lock_q, bdm_act_q};
            `MMMC_IDX_RSVD_A,
            `MMMC_IDX_RSVD_B,
            `MMMC_IDX_RSVD_C,
            `MMMC_IDX_RSVD_D,
            `MMMC_IDX_RSVD_E:  rdat = 8'h00;
            default:           rdat = 8'h00;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= acc;
        end
    end

    // Data only in the acked cycle, zero otherwise
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_dat_o <= acc ? {24'h000000, rdat} : 32'h00000000;
        end
    end

endmodule // mmmc_top

// ### mmmc_regs.vh
// Register indices, field positions and map constants for the mode control
`ifndef MMMC_REGS_VH
`define MMMC_REGS_VH

// Register indices; byte address is four times the index
`define MMMC_IDX_RSVD_A   6'h0A
`define MMMC_IDX_MODE     6'h0B
`define MMMC_IDX_RSVD_B   6'h10
`define MMMC_IDX_DIRECT   6'h11
`define MMMC_IDX_RSVD_C   6'h12
`define MMMC_IDX_RSVD_D   6'h13
`define MMMC_IDX_RSVD_E   6'h14
`define MMMC_IDX_FLASH_WINDOW_PAGE    6'h15
`define MMMC_IDX_BDMPAGE  6'h16
`define MMMC_IDX_STAT     6'h18
`define MMMC_IDX_MASK     6'h19
`define MMMC_IDX_CTRL     6'h1A

// Field positions
`define MMMC_MODE_BIT     7
`define MMMC_CTRL_BDM     0
`define MMMC_CTRL_LOCK    1
`define MMMC_CTRL_SEC     2

// Mode encoding
`define MMMC_MODE_NS      1'b1
`define MMMC_MODE_SS      1'b0

// Reset values
`define MMMC_FLASH_WINDOW_PAGE_RST    4'hE
`define MMMC_DIRECT_RST   8'h00
`define MMMC_MASK_RST     3'h0

// Fixed pages of the unpaged local windows
`define MMMC_PAGE_LOW     4'hC
`define MMMC_PAGE_MID     4'hD
`define MMMC_PAGE_TOP     4'hF
`define MMMC_WIN_LOW      2'b00
`define MMMC_WIN_MID      2'b01
`define MMMC_WIN_PAGED    2'b10

// Implemented resources; the gap between them is unmapped
`define MMMC_REG_TOP      16'h0400
`define MMMC_RAM_LO       16'h2000
`define MMMC_FLASH_PG_MIN 4'h8
`define MMMC_FLASH_BASE   18'h20000

// Event bits of the status register
`define MMMC_EV_UNIMPL    0
`define MMMC_EV_MODE      1
`define MMMC_EV_DENY      2
`define MMMC_EV_W         3

`endif

// ### mmmc_props.sv
// Port-level checks for the mode and map control unit
`timescale 1ns/1ps
module mmmc_chk (
    input wire        clk_i,
    input wire        rst_i,
    input wire        reset_pin_n_i,
    input wire        secure_i,
    input wire        cpu_req_i,
    input wire        cpu_direct_i,
    input wire [15:0] cpu_addr_i,
    input wire        bdm_req_i,
    input wire [17:0] mem_addr_o,
    input wire        mem_req_o,
    input wire        grant_cpu_o,
    input wire        grant_bdm_o,
    input wire        sys_reset_o,
    input wire        flash_deny_o,
    input wire        normal_single_chip_o,
    input wire        background_debug_mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence core_alone;
        cpu_req_i && !bdm_req_i && !cpu_direct_i;
    endsequence
    debug_wins_a: assert property (
        bdm_req_i |=> grant_bdm_o && !grant_cpu_o)
        else $error("debug master lost arbitration");
    core_grant_a: assert property (
        core_alone |=> grant_cpu_o)
        else $error("lone core request not granted");
    top_window_a: assert property (
        core_alone ##0 cpu_addr_i[15:14] == 2'b11 |=> mem_req_o
        && mem_addr_o == {4'hF, $past(cpu_addr_i[13:0])})
        else $error("top window mapped wrongly");
    unmapped_reset_a: assert property (
        core_alone ##0 (cpu_addr_i >= 16'h0400 && cpu_addr_i < 16'h2000)
        |=> sys_reset_o && !mem_req_o)
        else $error("unmapped core access without reset");
    deny_secure_a: assert property (
        flash_deny_o |-> $past(secure_i))
        else $error("flash denied while unsecured");
    secure_hold_a: assert property (
        (secure_i && reset_pin_n_i) [*6] |=> $stable(normal_single_chip_o))
        else $error("mode changed while secured");
    normal_hold_a: assert property (
        (normal_single_chip_o && reset_pin_n_i) [*6] |=> normal_single_chip_o)
        else $error("normal mode left by software");
    debug_entry_a: assert property (
        $fell(rst_i) |=> ##1
        (background_debug_mode_o == !normal_single_chip_o))
        else $error("debug entry after reset wrong");
endmodule // mmmc_chk

bind mmmc_top mmmc_chk chk_u (.*);

// ### mmmc_masters.sv
// Behavioural core and debug bus masters
`timescale 1ns/1ps
module mmmc_masters (
    input  wire        clk_i,
    output reg         cpu_req_i = 1'b0,
    output reg         cpu_direct_i = 1'b0,
    output reg  [15:0] cpu_addr_i = 16'h0000,
    output reg         bdm_req_i = 1'b0,
    output reg  [15:0] bdm_addr_i = 16'h0000
);
    // One-cycle request; idle address is inverted so stale values mislead
    task go(input logic c, input logic b, input logic d,
            input logic [15:0] a);
        @(posedge clk_i);
        cpu_req_i <= c;
        bdm_req_i <= b;
        cpu_direct_i <= d;
        cpu_addr_i <= a;
        bdm_addr_i <= a;
        @(posedge clk_i);
        cpu_req_i <= 1'b0;
        bdm_req_i <= 1'b0;
        cpu_addr_i <= ~a;
        bdm_addr_i <= ~a;
        // Results are read at the falling edge, once they have settled
        @(negedge clk_i);
    endtask
endmodule // mmmc_masters

// ### mmmc_top_tb.sv
// Self-checking bench for the mode and map control unit
`timescale 1ns/1ps
module mmmc_top_tb;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg         pin_n = 1'b0;
    reg         pin = 1'b0;
    reg         sec = 1'b0;
    reg         mwe = 1'b0;
    wire        mw;
    reg         cyc = 1'b0;
    reg         we = 1'b0;
    reg  [7:0]  adr = 8'h00;
    reg  [31:0] wd = 32'h0;
    reg  [7:0]  rd;
    wire [31:0] rdat;
    wire [15:0] ca, ba;
    wire [17:0] ma;
    wire        ack, cr, cd, br, mr, gc, gb, sr, dn, nsc, dbg, irq;
    integer     num_errors = 0;
    integer     checked = 0;
    integer     ticks = 0;

    mmmc_masters mst_u (.clk_i(clk_i), .cpu_req_i(cr), .cpu_direct_i(cd),
        .cpu_addr_i(ca), .bdm_req_i(br), .bdm_addr_i(ba));
    mmmc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .reset_pin_n_i(pin_n),
        .mode_select_pin_i(pin), .secure_i(sec), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd),
        .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack), .cpu_req_i(cr),
        .cpu_we_i(mwe), .cpu_direct_i(cd), .cpu_addr_i(ca),
        .bdm_req_i(br), .bdm_we_i(mwe), .bdm_addr_i(ba), .mem_req_o(mr),
        .mem_we_o(mw), .mem_addr_o(ma), .grant_cpu_o(gc), .grant_bdm_o(gb),
        .sys_reset_o(sr), .flash_deny_o(dn), .normal_single_chip_o(nsc),
        .background_debug_mode_o(dbg), .irq_o(irq));

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        ticks <= ticks + 1;
        if (ticks == 3000) begin
            num_errors = num_errors + 1;
            test_done;
        end
    end

    task test_done;
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string n, input logic [17:0] s, input logic [17:0] e);
        checked = checked + 1;
        if (s !== e) begin
            num_errors = num_errors + 1;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask
    task wb(input logic w, input logic [5:0] i, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wd <= {24'h0, d};
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        rd = rdat[7:0];
        cyc <= 1'b0;
    endtask
    task t_boot;
        chk("debug", dbg, 1);
        wb(0, 6'h0B, 0); chk("mode", rd, 0);
        wb(0, 6'h15, 0); chk("page", rd, 18'h0E);
        wb(0, 6'h0A, 0); chk("rsvd", rd, 0);
        wb(1, 6'h1A, 8'h01);
    endtask
    task t_paging;
        wb(1, 6'h15, 8'h05); mst_u.go(1, 0, 0, 16'h8123);
        chk("lowpage", sr, 1);
        wb(1, 6'h15, 8'h09); mst_u.go(1, 0, 0, 16'h8123);
        chk("paged", ma, 18'h24123);
        mwe <= 1'b1;
        mst_u.go(0, 1, 0, 16'h8001);
        chk("dbgmap", ma, 18'h38001);
        chk("dbgwe", mw, 1);
        mwe <= 1'b0;
    endtask
    task t_direct;
        wb(1, 6'h11, 8'h80); wb(1, 6'h11, 8'h40); wb(0, 6'h11, 0);
        chk("direct", rd, 18'h40);
        mst_u.go(1, 0, 1, 16'h0034);
        chk("dpage", ma, 18'h34034);
        mst_u.go(1, 0, 0, 16'h0500);
        chk("unmap", sr, 1);
        mst_u.go(1, 0, 0, 16'hC010);
        chk("top", ma, 18'h3C010);
        mst_u.go(1, 1, 0, 16'hC010);
        chk("tie", {gb, gc}, 2'b10);
    endtask
    task t_mode;
        wb(1, 6'h0B, 8'h80); wb(0, 6'h0B, 0);
        chk("tons", rd, 18'h80);
        wb(1, 6'h0B, 0); wb(0, 6'h0B, 0);
        chk("locked", rd, 18'h80);
        wb(1, 6'h11, 8'h22); wb(0, 6'h11, 0);
        chk("dironce", rd, 18'h40);
        chk("irqoff", irq, 0);
        wb(1, 6'h19, 8'h02); repeat (2) @(posedge clk_i);
        chk("irqon", irq, 1);
        wb(1, 6'h18, 8'h02); repeat (2) @(posedge clk_i);
        chk("irqclr", irq, 0);
    endtask
    // Pin reset clears the lock, so secure must be up before it
    task t_secure;
        @(posedge clk_i);
        sec <= 1'b1;
        pin_n <= 1'b0;
        repeat (8) @(posedge clk_i);
        pin_n <= 1'b1;
        repeat (8) @(posedge clk_i);
        wb(0, 6'h0B, 0); chk("pinmode", rd, 0);
        wb(1, 6'h0B, 8'h80); wb(0, 6'h0B, 0);
        chk("secmode", rd, 0);
        mst_u.go(0, 1, 0, 16'h8000);
        chk("deny", {dn, mr}, 2'b10);
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        pin_n <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        t_boot;
        t_paging;
        t_direct;
        t_mode;
        t_secure;
        test_done;
    end
endmodule // mmmc_top_tb
